// File: common/bpo_pkg.sv
// Summary of operation
// - Direction bit one makes pin input, high impedance; zero drives latch bit.
// - Latch register reads back latched output value, not pin levels.
// - Every reset sets all second-port direction bits; pins become inputs unless the memory bus, enabled at reset, drives them.
// - Second port is 3 bits on small packages, 8 bits on largest.
// - Enabled memory bus owns second port and overrides its direction bits.
// - Shared pull-up bit 7 of third-port latch enables all second-port pull-ups.
// - Pull-up is off on any second-port pin configured as output.
// - Shared pull-up enable is cleared on every reset.
// - Parallel slave mode overrides port I/O but yields to memory bus.
// - Don't-care direction functions ignore the direction bit.
// - Sync serial data out drives first-port bit 5 over latch data.
// - Two-wire data overrides bit 4 latch; pin feeds both serial inputs.
// - USART sync data outputs on bits 6 and 7 override latch data.
// - Bit 6 feeds USART sync clock input in synchronous slave mode.
// - Bit 7 feeds USART asynchronous receive input.
package bpo_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_FIRST_PINS = 8'h00;
  localparam logic [7:0] OFS_FIRST_LATCH = 8'h04;
  localparam logic [7:0] OFS_FIRST_DIR = 8'h08;
  localparam logic [7:0] OFS_SECOND_PINS = 8'h0C;
  localparam logic [7:0] OFS_SECOND_LATCH = 8'h10;
  localparam logic [7:0] OFS_SECOND_DIR = 8'h14;
  localparam logic [7:0] OFS_THIRD_LATCH = 8'h18;
  localparam logic [7:0] OFS_MEM_CTRL = 8'h1C;
  localparam logic [7:0] OFS_PAR_CTRL = 8'h20;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PULLUP_BIT = 7;
  localparam int EXT_BUS_DISABLE_BIT = 7;
  localparam int PAR_SLAVE_BIT = 4;
  localparam int SDO_BIT = 5;
  localparam int SDA_BIT = 4;
  localparam int TX_BIT = 6;
  localparam int RX_BIT = 7;
  // ----------------------------------------
  // Reset values and widths
  // ----------------------------------------
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] MEM_CTRL_RESET = 8'h00;
  localparam int SECOND_WIDTH_SMALL = 3;
  localparam int SECOND_WIDTH_LARGE = 8;
endpackage

// File: design/bpo_sync2.sv
module bpo_sync2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stage <= '0;
      dout <= '0;
    end else begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule

// File: design/bpo_port.sv
// The implementer's own choices: the APB register port and the placing of the registers.
module bpo_port import bpo_pkg::*; #(
  parameter int SECOND_WIDTH = SECOND_WIDTH_LARGE
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // First-port pins
  input wire logic [7:0] first_pin_in,
  output logic [7:0] first_pin_out,
  output logic [7:0] first_pin_oe,
  // Second-port pins
  input wire logic [7:0] second_pin_in,
  output logic [7:0] second_pin_out,
  output logic [7:0] second_pin_oe,
  output logic [7:0] second_pullup_on,
  // Serial module one
  input wire logic sync_serial_data_out,
  input wire logic sync_serial_out_en,
  input wire logic two_wire_data,
  input wire logic two_wire_out_en,
  output logic sync_serial_data_in,
  output logic two_wire_data_in,
  // USART one
  input wire logic usart_sync_mode,
  input wire logic usart_sync_slave,
  input wire logic usart_transmit,
  input wire logic usart_sync_data,
  input wire logic usart_sync_data_out_en,
  output logic usart_sync_clock,
  output logic usart_receive,
  output logic usart_sync_data_in,
  // Memory bus
  input wire logic [7:0] mem_ad_out,
  input wire logic mem_ad_oe,
  output logic [7:0] mem_ad_in,
  // Parallel slave port
  input wire logic psp_read_drive,
  output logic [7:0] psp_data_in,
  output logic psp_mode_active,
  // Register state
  output logic [7:0] third_port_latch
);
  // ----------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------
  logic rst_meta;
  logic rst_sync;
  logic [7:0] first_sampled;
  logic [7:0] second_sampled;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  bpo_sync2 #(.WIDTH(8)) u_first_sync (
    .mclk(mclk),
    .rst_b(rst_sync),
    .din(first_pin_in),
    .dout(first_sampled)
  );

  bpo_sync2 #(.WIDTH(8)) u_second_sync (
    .mclk(mclk),
    .rst_b(rst_sync),
    .din(second_pin_in),
    .dout(second_sampled)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam logic [7:0] IMPL_MASK = 8'((9'h001 << SECOND_WIDTH) - 9'h001);

  logic [7:0] first_port_latch;
  logic [7:0] first_port_direction;
  logic [7:0] second_port_latch;
  logic [7:0] second_port_direction;
  logic [7:0] memory_bus_control;
  logic [7:0] parallel_port_control;
  logic wr_en;
  logic mapped;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      OFS_FIRST_PINS, OFS_FIRST_LATCH, OFS_FIRST_DIR, OFS_SECOND_PINS, OFS_SECOND_LATCH,
      OFS_SECOND_DIR, OFS_THIRD_LATCH, OFS_MEM_CTRL, OFS_PAR_CTRL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  // First port: pin register write lands in the latch
  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      first_port_latch <= LATCH_RESET;
      first_port_direction <= DIR_RESET;
    end else if (wr_en) begin
      if (paddr == OFS_FIRST_PINS || paddr == OFS_FIRST_LATCH) begin
        first_port_latch <= pwdata[7:0];
      end
      if (paddr == OFS_FIRST_DIR) begin
        first_port_direction <= pwdata[7:0];
      end
    end
  end

  // Second port: unimplemented bits stay inputs, latch bits stay zero
  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      second_port_latch <= LATCH_RESET;
      second_port_direction <= DIR_RESET;
    end else if (wr_en) begin
      if (paddr == OFS_SECOND_PINS || paddr == OFS_SECOND_LATCH) begin
        second_port_latch <= pwdata[7:0] & IMPL_MASK;
      end
      if (paddr == OFS_SECOND_DIR) begin
        second_port_direction <= pwdata[7:0] | ~IMPL_MASK;
      end
    end
  end

  // Control registers; reset leaves the memory bus enabled and pull-ups off
  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      third_port_latch <= LATCH_RESET;
      memory_bus_control <= MEM_CTRL_RESET;
      parallel_port_control <= LATCH_RESET;
    end else if (wr_en) begin
      if (paddr == OFS_THIRD_LATCH) begin
        third_port_latch <= pwdata[7:0];
      end
      if (paddr == OFS_MEM_CTRL) begin
        memory_bus_control <= pwdata[7:0];
      end
      if (paddr == OFS_PAR_CTRL) begin
        parallel_port_control <= pwdata[7:0];
      end
    end
  end

  // Read data registered at setup so it is stable in the access phase
  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_FIRST_PINS: prdata <= {24'h000000, first_sampled};
        OFS_FIRST_LATCH: prdata <= {24'h000000, first_port_latch};
        OFS_FIRST_DIR: prdata <= {24'h000000, first_port_direction};
        OFS_SECOND_PINS: prdata <= {24'h000000, second_sampled & IMPL_MASK};
        OFS_SECOND_LATCH: prdata <= {24'h000000, second_port_latch};
        OFS_SECOND_DIR: prdata <= {24'h000000, second_port_direction};
        OFS_THIRD_LATCH: prdata <= {24'h000000, third_port_latch};
        OFS_MEM_CTRL: prdata <= {24'h000000, memory_bus_control};
        OFS_PAR_CTRL: prdata <= {24'h000000, parallel_port_control};
        default: prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // First-port pin muxing
  // ----------------------------------------
  // Direction register keeps its value even while a peripheral overrides a pin
  always_comb begin
    first_pin_out = first_port_latch;
    first_pin_oe = ~first_port_direction;
    if (sync_serial_out_en) begin
      first_pin_out[SDO_BIT] = sync_serial_data_out;
      first_pin_oe[SDO_BIT] = 1'b1;
    end
    if (two_wire_out_en) begin
      first_pin_out[SDA_BIT] = two_wire_data;
      first_pin_oe[SDA_BIT] = 1'b1;
    end
    if (usart_sync_mode) begin
      first_pin_out[TX_BIT] = usart_transmit;
      first_pin_oe[TX_BIT] = !usart_sync_slave;
      if (usart_sync_data_out_en) begin
        first_pin_out[RX_BIT] = usart_sync_data;
        first_pin_oe[RX_BIT] = 1'b1;
      end
    end
  end

  assign two_wire_data_in = first_sampled[SDA_BIT];
  assign sync_serial_data_in = first_sampled[SDA_BIT];
  assign usart_sync_clock = usart_sync_mode && usart_sync_slave && first_sampled[TX_BIT];
  assign usart_receive = first_sampled[RX_BIT];
  // Direction of the data-in pin is left to software here
  assign usart_sync_data_in = first_sampled[RX_BIT];

  // ----------------------------------------
  // Second-port pin muxing
  // ----------------------------------------
  logic mem_bus_on;
  logic psp_on;

  // Memory bus and parallel port only exist on the full-width port
  assign mem_bus_on = (SECOND_WIDTH == SECOND_WIDTH_LARGE) &&
                      !memory_bus_control[EXT_BUS_DISABLE_BIT];
  assign psp_on = (SECOND_WIDTH == SECOND_WIDTH_LARGE) && !mem_bus_on &&
                  parallel_port_control[PAR_SLAVE_BIT];
  assign psp_mode_active = psp_on;
  assign mem_ad_in = mem_bus_on ? second_sampled : 8'h00;
  assign psp_data_in = psp_on ? second_sampled : 8'h00;

  always_comb begin
    if (mem_bus_on) begin
      second_pin_out = mem_ad_out;
      second_pin_oe = {8{mem_ad_oe}};
    end else if (psp_on) begin
      second_pin_out = second_port_latch;
      second_pin_oe = {8{psp_read_drive}};
    end else begin
      second_pin_out = second_port_latch;
      second_pin_oe = ~second_port_direction & IMPL_MASK;
    end
  end

  // Pull-ups track the effective driver, so any driving pin loses its pull-up
  assign second_pullup_on = {8{third_port_latch[PULLUP_BIT]}} & ~second_pin_oe & IMPL_MASK;

  // ----------------------------------------
  // Assertions on the second port
  // ----------------------------------------
  pullup_off_out_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    (second_pullup_on & second_pin_oe) == 8'h00)
    else $error("pull-up on while driving");

  pullup_follow_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    (wr_en && paddr == OFS_THIRD_LATCH && pwdata[PULLUP_BIT] && !mem_bus_on && !psp_on
     && second_port_direction == 8'hFF) |=> second_pullup_on == IMPL_MASK)
    else $error("pull-ups not enabled");

  pullup_gate_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    !third_port_latch[PULLUP_BIT] |-> second_pullup_on == 8'h00)
    else $error("pull-up without enable");

  dir_drive_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    (!mem_bus_on && !psp_on) |-> second_pin_oe == (~second_port_direction & IMPL_MASK))
    else $error("second port drive mismatch");

  dir_width_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    (wr_en && paddr == OFS_SECOND_DIR)
    |=> second_port_direction == ($past(pwdata[7:0]) | ~IMPL_MASK))
    else $error("direction write wrong");

  // Missing pins of a short port must never drive or pull
  unimpl_idle_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    !mem_bus_on |-> ((second_pin_oe | second_pullup_on) & ~IMPL_MASK) == 8'h00)
    else $error("missing pin active");

  mem_priority_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    mem_bus_on |-> (!psp_on && second_pin_oe == {8{mem_ad_oe}}))
    else $error("memory bus lost priority");

  bus_data_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    mem_bus_on |-> (second_pin_out == mem_ad_out && mem_ad_in == second_sampled))
    else $error("memory bus data wrong");

  psp_drive_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    psp_on |-> (second_pin_oe == {8{psp_read_drive}} && second_pin_out == second_port_latch))
    else $error("parallel port drive wrong");

  psp_data_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    psp_on |-> psp_data_in == second_sampled)
    else $error("parallel data wrong");

  latch_read_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    (psel && !penable && !pwrite && paddr == OFS_SECOND_LATCH)
    |=> prdata[7:0] == $past(second_port_latch))
    else $error("latch readback wrong");

  reset_inputs_a: assert property (@(posedge mclk)
    $rose(rst_sync) |-> (second_port_direction == 8'hFF && !third_port_latch[PULLUP_BIT]))
    else $error("reset state wrong");

  // ----------------------------------------
  // Assertions on the first port
  // ----------------------------------------
  first_dir_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    (!sync_serial_out_en && !two_wire_out_en && !usart_sync_mode)
    |-> (first_pin_oe == ~first_port_direction && first_pin_out == first_port_latch))
    else $error("first port drive mismatch");

  latch_rmw_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    (wr_en && paddr == OFS_FIRST_PINS) |=> first_port_latch == $past(pwdata[7:0]))
    else $error("pin write missed latch");

  // Read data is caught at setup, so it matches the pins one edge back
  pin_read_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    (psel && !penable && !pwrite && paddr == OFS_FIRST_PINS)
    |=> prdata[7:0] == $past(first_sampled))
    else $error("pin read wrong");

  sdo_priority_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    sync_serial_out_en |-> (first_pin_out[SDO_BIT] == sync_serial_data_out && first_pin_oe[SDO_BIT]))
    else $error("serial out not driven");

  sda_priority_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    two_wire_out_en |-> (first_pin_out[SDA_BIT] == two_wire_data && first_pin_oe[SDA_BIT]))
    else $error("two-wire data not driven");

  serial_inputs_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    (two_wire_data_in == first_sampled[SDA_BIT] && sync_serial_data_in == first_sampled[SDA_BIT]))
    else $error("data pin not shared");

  tx_priority_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    usart_sync_mode |-> first_pin_out[TX_BIT] == usart_transmit)
    else $error("usart output not driven");

  dt_priority_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    (usart_sync_mode && usart_sync_data_out_en)
    |-> (first_pin_out[RX_BIT] == usart_sync_data && first_pin_oe[RX_BIT]))
    else $error("usart data not driven");

  sync_clock_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    (usart_sync_mode && usart_sync_slave) |-> usart_sync_clock == first_sampled[TX_BIT])
    else $error("sync clock not passed");

  clock_idle_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    !usart_sync_slave |-> !usart_sync_clock)
    else $error("sync clock outside slave mode");

  receive_in_a: assert property (@(posedge mclk) disable iff (!rst_sync)
    usart_receive == first_sampled[RX_BIT])
    else $error("receive input wrong");
endmodule

// File: sim/bpo_pin_model.sv
module bpo_pin_model (
  // Clock
  input wire logic mclk,
  // Block side
  input wire logic [7:0] drv_out,
  input wire logic [7:0] drv_oe,
  input wire logic [7:0] pull_on,
  // Board side
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last = 8'h00;
  // Undriven pins without pull-up toggle, so a stale value never passes for a driven one
  always_comb level = (drv_oe & drv_out) | (~drv_oe & ext_en & ext_val) |
                      (~drv_oe & ~ext_en & (pull_on | ~last));
  always_ff @(posedge mclk) last <= level;
endmodule

// File: sim/bidir_port_with_overrides_test.sv
module bidir_port_with_overrides_test import bpo_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic x;} bpo_tb_row_s;
  logic mclk = 0, rst_b = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00, p1_in, p1_out, p1_oe, p2_in, p2_out, p2_oe, pull, mem_in, psp_in, third, s_oe;
  logic [7:0] p1_ext = 0, p1_en = 0, p2_ext = 0, p2_en = 0, mem_out = 0;
  logic [31:0] pwdata = 0, prdata, prdata_s, rd, rd_s;
  logic sdo = 0, sdo_en = 0, sda = 0, sda_en = 0, u_mode = 0, u_slave = 0, u_tx = 0, u_dt = 0, u_dt_en = 0;
  logic mem_oe = 0, psp_drv = 0, sdi, sda_in, u_ck, u_rx, u_dt_in, psp_act;
  int miscompares = 0, comparisons = 0;
  bpo_tb_row_s rows [8] = '{'{OFS_FIRST_LATCH, 8'hA5, 8'hA5, 0}, '{OFS_FIRST_DIR, 8'h3C, 8'h3C, 0},
    '{OFS_SECOND_LATCH, 8'h5A, 8'h5A, 0}, '{OFS_SECOND_DIR, 8'hC3, 8'hC3, 0}, '{OFS_THIRD_LATCH, 8'h7F, 8'h7F, 0},
    '{OFS_MEM_CTRL, 8'h80, 8'h80, 0}, '{OFS_PAR_CTRL, 8'h10, 8'h10, 0}, '{8'h24, 8'hFF, 8'h00, 1}};
  always #5 mclk = ~mclk;
  // ----------------------------------------
  // Design and pins
  // ----------------------------------------
  bpo_port i_bpo_port (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .first_pin_in(p1_in),
    .first_pin_out(p1_out), .first_pin_oe(p1_oe), .second_pin_in(p2_in), .second_pin_out(p2_out),
    .second_pin_oe(p2_oe), .second_pullup_on(pull), .sync_serial_data_out(sdo), .sync_serial_out_en(sdo_en),
    .two_wire_data(sda), .two_wire_out_en(sda_en), .sync_serial_data_in(sdi), .two_wire_data_in(sda_in),
    .usart_sync_mode(u_mode), .usart_sync_slave(u_slave), .usart_transmit(u_tx), .usart_sync_data(u_dt),
    .usart_sync_data_out_en(u_dt_en), .usart_sync_clock(u_ck), .usart_receive(u_rx), .usart_sync_data_in(u_dt_in),
    .mem_ad_out(mem_out), .mem_ad_oe(mem_oe), .mem_ad_in(mem_in), .psp_read_drive(psp_drv),
    .psp_data_in(psp_in), .psp_mode_active(psp_act), .third_port_latch(third));
  // Small package variant shares the bus; only its read data and enables are watched
  bpo_port #(.SECOND_WIDTH(SECOND_WIDTH_SMALL)) i_bpo_port_small (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_s), .pready(),
    .pslverr(), .first_pin_in(p1_in), .first_pin_out(), .first_pin_oe(), .second_pin_in(p2_in),
    .second_pin_out(), .second_pin_oe(s_oe), .second_pullup_on(), .sync_serial_data_out(sdo),
    .sync_serial_out_en(sdo_en), .two_wire_data(sda), .two_wire_out_en(sda_en), .sync_serial_data_in(),
    .two_wire_data_in(), .usart_sync_mode(u_mode), .usart_sync_slave(u_slave), .usart_transmit(u_tx),
    .usart_sync_data(u_dt), .usart_sync_data_out_en(u_dt_en), .usart_sync_clock(), .usart_receive(),
    .usart_sync_data_in(), .mem_ad_out(mem_out), .mem_ad_oe(mem_oe), .mem_ad_in(), .psp_read_drive(psp_drv),
    .psp_data_in(), .psp_mode_active(), .third_port_latch());
  bpo_pin_model i_pins1 (.mclk(mclk), .drv_out(p1_out), .drv_oe(p1_oe), .pull_on(8'h00), .ext_val(p1_ext),
    .ext_en(p1_en), .level(p1_in));
  bpo_pin_model i_pins2 (.mclk(mclk), .drv_out(p2_out), .drv_oe(p2_oe), .pull_on(pull), .ext_val(p2_ext),
    .ext_en(p2_en), .level(p2_in));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge mclk);
    end
    if (n == 50) begin
      miscompares++;
      $display("FAIL %0t no pready", $time);
    end
    rd = prdata;
    rd_s = prdata_s;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic do_reset();
    // Falling edge at once, so no register is left unknown before the first clock
    rst_b <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200us;
    miscompares++;
    $display("FAIL %0t watchdog", $time);
    complete_run();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    do_reset();
    apb(0, OFS_SECOND_DIR, 0);
    chk(rd[7:0], DIR_RESET, "second dir reset");
    apb(0, OFS_THIRD_LATCH, 0);
    chk(rd[7:0], LATCH_RESET, "pull-up enable reset");
    chk(pull, 8'h00, "pull-ups at reset");
    chk(third, LATCH_RESET, "third latch at reset");
    mem_oe <= 1'b1;
    mem_out <= 8'hA5;
    wt(1);
    chk(p2_out, 8'hA5, "bus drives port");
    chk(p2_oe, 8'hFF, "bus overrides dir");
    chk(s_oe, 8'h00, "small has no bus");
    @(posedge mclk);
    mem_oe <= 1'b0;
    p2_ext <= 8'h3C;
    p2_en <= 8'hFF;
    wt(4);
    chk(mem_in, 8'h3C, "bus input");
    $display("test reset and bus done");
    for (int i = 0; i < 8; i++) begin
      apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 0);
      chk(rd[7:0], rows[i].e, "register readback");
      chk({7'h0, err}, {7'h0, rows[i].x}, "slave error");
    end
    apb(0, OFS_SECOND_DIR, 0);
    chk(rd_s[7:0], 8'hFB, "small dir width");
    chk(s_oe, 8'h04, "small pin drive");
    $display("test register table done");
    do_reset();
    p2_en <= 8'h00;
    apb(1, OFS_MEM_CTRL, 8'h80);
    apb(1, OFS_THIRD_LATCH, 8'h80);
    wt(4);
    chk(pull, 8'hFF, "shared pull-up");
    chk(third, 8'h80, "pull-up enable bit");
    apb(0, OFS_SECOND_PINS, 0);
    chk(rd[7:0], 8'hFF, "pulled pins");
    apb(1, OFS_SECOND_DIR, 8'h0F);
    apb(1, OFS_SECOND_PINS, 8'hA0);
    wt(1);
    chk(pull, 8'h0F, "pull-up off on outputs");
    chk(p2_oe & p2_out, 8'hA0, "port output");
    apb(0, OFS_SECOND_LATCH, 0);
    chk(rd[7:0], 8'hA0, "latch readback");
    apb(1, OFS_SECOND_LATCH, 8'h3C);
    apb(1, OFS_PAR_CTRL, 8'h10);
    psp_drv <= 1'b1;
    wt(1);
    chk({7'h0, psp_act}, 8'h01, "parallel mode on");
    chk(p2_out, 8'h3C, "parallel read data");
    chk(p2_oe, 8'hFF, "parallel drive");
    @(posedge mclk);
    psp_drv <= 1'b0;
    p2_ext <= 8'h5A;
    p2_en <= 8'hFF;
    wt(4);
    chk(p2_oe, 8'h00, "parallel input");
    chk(psp_in, 8'h5A, "parallel write data");
    apb(1, OFS_MEM_CTRL, 8'h00);
    mem_oe <= 1'b1;
    mem_out <= 8'h81;
    p2_en <= 8'h00;
    wt(1);
    chk({7'h0, psp_act}, 8'h00, "parallel yields");
    chk(p2_out, 8'h81, "bus wins");
    $display("test second port done");
    mem_oe <= 1'b0;
    apb(1, OFS_FIRST_DIR, 8'hDF);
    apb(1, OFS_FIRST_LATCH, 8'h00);
    sdo_en <= 1'b1;
    sdo <= 1'b1;
    sda_en <= 1'b1;
    sda <= 1'b1;
    wt(1);
    chk({7'h0, p1_out[5]}, 8'h01, "serial out wins");
    chk({6'h0, p1_oe[4], p1_out[4]}, 8'h03, "two-wire out wins");
    @(posedge mclk);
    sdo_en <= 1'b0;
    sda_en <= 1'b0;
    u_mode <= 1'b1;
    u_tx <= 1'b1;
    u_dt_en <= 1'b1;
    wt(1);
    chk({4'h0, p1_oe[7:6], p1_out[7:6]}, 8'h0D, "usart outputs win");
    @(posedge mclk);
    u_tx <= 1'b0;
    u_dt_en <= 1'b0;
    u_slave <= 1'b1;
    p1_ext <= 8'hD0;
    p1_en <= 8'hD0;
    wt(4);
    chk({3'h0, u_ck, u_rx, u_dt_in, sdi, sda_in}, 8'h1F, "inputs high");
    @(posedge mclk);
    u_mode <= 1'b0;
    p1_ext <= 8'h00;
    wt(4);
    chk({5'h0, u_ck, u_rx, sdi}, 8'h00, "inputs low");
    apb(1, OFS_FIRST_DIR, 8'hFF);
    p1_ext <= 8'h96;
    p1_en <= 8'hFF;
    apb(1, OFS_FIRST_PINS, 8'h21);
    wt(4);
    chk(p1_oe, 8'h00, "all inputs");
    apb(0, OFS_FIRST_PINS, 0);
    chk(rd[7:0], 8'h96, "pin levels");
    apb(0, OFS_FIRST_LATCH, 0);
    chk(rd[7:0], 8'h21, "latch not pins");
    $display("test first port done");
    complete_run();
  end
endmodule
